// File: design/sdm_cfg_regs.sv
// Modulator configuration register with seed transfer, clock routing and reference-divider self test
// Functional notes
// - Seed code picks zero, lsb, two constants
// - Stored seed loaded on frequency change if autoseed
// - Order 2 mode B, 3 mode A, rest reserved
// - Bypass ignores output; core keeps clocking when enabled
// - Autoseed reloads seed on each fractional write
// - Source bit picks VCO/ref divider unless overridden
// - Core clock select picks delayed VCO; test force bit 21 picks auxiliary
// - Core enable bit gates modulator core
// - Self test enable; length 1023 to 4095 cycles
module sdm_cfg_regs (
    input  wire logic                          ref_clk_i,
    input  wire logic                          nrst_i,
    input  wire sdm_cfg_pkg::sdm_reg_req_type  reg_req_i,
    input  wire logic                          frac_write_i,
    input  wire logic                          refdiv_tick_i,
    output logic [23:0]                        reg_rdata_o,
    output sdm_cfg_pkg::sdm_mod_ctrl_type      mod_ctrl_o
);

    typedef struct packed {
        logic [22:0]                     cfg;
        sdm_cfg_pkg::sdm_mod_ctrl_type   ctrl;
        logic [11:0]                     test_count;
        sdm_cfg_pkg::sdm_test_state_type test_state;
    } sdm_state_type;

    sdm_state_type state;
    sdm_state_type next_state;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] sdm_seed_decode(input logic [1:0] code);
        unique case (code)
            2'h0: sdm_seed_decode = sdm_cfg_pkg::SEED_ZERO;
            2'h1: sdm_seed_decode = sdm_cfg_pkg::SEED_LSB_VAL;
            2'h2: sdm_seed_decode = sdm_cfg_pkg::SEED_CONST2;
            2'h3: sdm_seed_decode = sdm_cfg_pkg::SEED_CONST3;
        endcase
    endfunction : sdm_seed_decode

    // Bit 10 outranks bit 21, and either of them overrides the divider source bit
    function automatic sdm_cfg_pkg::sdm_clk_src_type sdm_clk_route(input logic [22:0] cfg);
        if (cfg[sdm_cfg_pkg::CORESEL_BIT]) begin
            sdm_clk_route = sdm_cfg_pkg::SDM_CLK_VCO_DELAY;
        end else if (cfg[sdm_cfg_pkg::TEST_FORCE_BIT]) begin
            sdm_clk_route = sdm_cfg_pkg::SDM_CLK_AUX;
        end else if (cfg[sdm_cfg_pkg::REFSEL_BIT]) begin
            sdm_clk_route = sdm_cfg_pkg::SDM_CLK_VCO_DIV;
        end else begin
            sdm_clk_route = sdm_cfg_pkg::SDM_CLK_REF_DIV;
        end
    endfunction : sdm_clk_route

    // Level controls that follow from a stored word; seed and self-test fields pass through
    function automatic sdm_cfg_pkg::sdm_mod_ctrl_type sdm_ctrl_decode(
        input logic [22:0]                   cfg,
        input sdm_cfg_pkg::sdm_mod_ctrl_type keep
    );
        logic [1:0] order;
        order                          = cfg[sdm_cfg_pkg::ORDER_LSB +: 2];
        sdm_ctrl_decode                = keep;
        sdm_ctrl_decode.mode_a         = (order == sdm_cfg_pkg::ORDER_MODE_A);
        sdm_ctrl_decode.order_reserved = (order != sdm_cfg_pkg::ORDER_MODE_A) &&
                                         (order != sdm_cfg_pkg::ORDER_MODE_B);
        sdm_ctrl_decode.use_modulator  = !cfg[sdm_cfg_pkg::BYPASS_BIT];
        // Bypass only drops the output; clocking follows the core enable alone
        sdm_ctrl_decode.core_enable    = cfg[sdm_cfg_pkg::CORE_EN_BIT];
        sdm_ctrl_decode.clk_src        = sdm_clk_route(cfg);
        // Trim is meaningless in mode B, so it is masked rather than passed on
        sdm_ctrl_decode.rate_trim      = sdm_ctrl_decode.mode_a ? cfg[sdm_cfg_pkg::RATE_LSB +: 2] : 2'h0;
    endfunction : sdm_ctrl_decode

    ////////////////////////////////////////////////////////////////////////////////
    logic        cfg_hit;
    logic        autoseed;
    logic        test_en;
    logic [11:0] test_len;
    logic [1:0]  seed_code;

    assign cfg_hit  = reg_req_i.wr && (reg_req_i.addr == sdm_cfg_pkg::CFG_ADDR);
    assign seed_code = state.cfg[sdm_cfg_pkg::SEED_LSB +: 2];
    assign autoseed = state.cfg[sdm_cfg_pkg::AUTOSEED_BIT];
    assign test_en  = state.cfg[sdm_cfg_pkg::TEST_EN_BIT];
    assign test_len = {state.cfg[sdm_cfg_pkg::TEST_LEN_LSB +: 2], sdm_cfg_pkg::TEST_LEN_BASE};

    always_comb begin
        next_state                = state;
        next_state.ctrl.seed_load = 1'b0;
        if (cfg_hit) begin
            // Seed code is only stored here; the modulator sees it at the next fractional write with autoseed set
            next_state.cfg = reg_req_i.wdata[22:0] & sdm_cfg_pkg::CFG_WR_MASK;
        end
        if (frac_write_i && autoseed) begin
            next_state.ctrl.seed_value = sdm_seed_decode(seed_code);
            next_state.ctrl.seed_load  = 1'b1;
        end
        unique case (state.test_state)
            sdm_cfg_pkg::SDM_TEST_IDLE: begin
                if (test_en) begin
                    next_state.test_state = sdm_cfg_pkg::SDM_TEST_RUN;
                    next_state.test_count = 12'h000;
                end
            end
            sdm_cfg_pkg::SDM_TEST_RUN: begin
                if (!test_en) begin
                    next_state.test_state = sdm_cfg_pkg::SDM_TEST_IDLE;
                end else if (refdiv_tick_i) begin
                    if (state.test_count == test_len - 12'h001) begin
                        next_state.test_state = sdm_cfg_pkg::SDM_TEST_DONE;
                    end
                    next_state.test_count = state.test_count + 12'h001;
                end
            end
            sdm_cfg_pkg::SDM_TEST_DONE: begin
                // Result holds until software drops the enable, so it cannot be missed
                if (!test_en) begin
                    next_state.test_state = sdm_cfg_pkg::SDM_TEST_IDLE;
                end
            end
            default: next_state.test_state = sdm_cfg_pkg::SDM_TEST_IDLE;
        endcase
        // Controls are registered from the next word, so they move on the same edge as the read-back
        next_state.ctrl           = sdm_ctrl_decode(next_state.cfg, next_state.ctrl);
        next_state.ctrl.test_busy = (next_state.test_state == sdm_cfg_pkg::SDM_TEST_RUN);
        next_state.ctrl.test_done = (next_state.test_state == sdm_cfg_pkg::SDM_TEST_DONE);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state.cfg        <= sdm_cfg_pkg::CFG_RESET;
            // Decoded fields match the reset word: mode B, modulator used, VCO divider clock
            state.ctrl.seed_value     <= sdm_cfg_pkg::SEED_CONST2;
            state.ctrl.seed_load      <= 1'b0;
            state.ctrl.mode_a         <= 1'b0;
            state.ctrl.order_reserved <= 1'b0;
            state.ctrl.use_modulator  <= !sdm_cfg_pkg::CFG_RESET[sdm_cfg_pkg::BYPASS_BIT];
            state.ctrl.core_enable    <= sdm_cfg_pkg::CFG_RESET[sdm_cfg_pkg::CORE_EN_BIT];
            state.ctrl.clk_src        <= sdm_cfg_pkg::SDM_CLK_VCO_DIV;
            state.ctrl.rate_trim      <= 2'h0;
            state.ctrl.test_busy      <= 1'b0;
            state.ctrl.test_done      <= 1'b0;
            state.test_count <= 12'h000;
            state.test_state <= sdm_cfg_pkg::SDM_TEST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o = {1'b0, state.cfg};
    assign mod_ctrl_o  = state.ctrl;

endmodule : sdm_cfg_regs

// File: include/sdm_cfg_pkg.sv
// Package: field layout, reset values and types of the modulator configuration register
package sdm_cfg_pkg;

    localparam logic [4:0]  CFG_ADDR      = 5'h06;
    localparam int          CFG_WIDTH     = 23;
    localparam logic [22:0] CFG_RESET     = 23'h000B7A;
    localparam logic [22:0] CFG_WR_MASK   = 23'h7FFFFF;

    localparam int SEED_LSB    = 0;
    localparam int ORDER_LSB   = 2;
    localparam int BYPASS_BIT  = 7;
    localparam int AUTOSEED_BIT = 8;
    localparam int REFSEL_BIT  = 9;
    localparam int CORESEL_BIT = 10;
    localparam int CORE_EN_BIT = 11;
    localparam int RATE_LSB    = 16;
    localparam int TEST_EN_BIT = 18;
    localparam int TEST_LEN_LSB = 19;
    localparam int TEST_FORCE_BIT = 21;

    localparam logic [23:0] SEED_ZERO = 24'h000000;
    localparam logic [23:0] SEED_LSB_VAL = 24'h000001;
    localparam logic [23:0] SEED_CONST2 = 24'hB29D08;
    localparam logic [23:0] SEED_CONST3 = 24'h50F1CD;

    localparam logic [1:0]  ORDER_MODE_B = 2'h2;
    localparam logic [1:0]  ORDER_MODE_A = 2'h3;

    localparam logic [9:0]  TEST_LEN_BASE = 10'h3FF;

    typedef enum logic [1:0] {
        SDM_CLK_AUX,
        SDM_CLK_VCO_DELAY,
        SDM_CLK_VCO_DIV,
        SDM_CLK_REF_DIV
    } sdm_clk_src_type;

    typedef enum logic [1:0] {
        SDM_TEST_IDLE,
        SDM_TEST_RUN,
        SDM_TEST_DONE
    } sdm_test_state_type;

    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [23:0] wdata;
    } sdm_reg_req_type;

    typedef struct packed {
        logic [23:0]     seed_value;
        logic            seed_load;
        logic            mode_a;
        logic            order_reserved;
        logic            use_modulator;
        logic            core_enable;
        sdm_clk_src_type clk_src;
        logic [1:0]      rate_trim;
        logic            test_busy;
        logic            test_done;
    } sdm_mod_ctrl_type;

endpackage : sdm_cfg_pkg

// File: testbench/sdm_cfg_regs_properties.sv
// Checker for the modulator configuration register ports
module sdm_cfg_regs_properties (
    input wire logic                         ref_clk_i,
    input wire logic                         nrst_i,
    input wire sdm_cfg_pkg::sdm_reg_req_type reg_req_i,
    input wire logic                         frac_write_i,
    input wire logic                         refdiv_tick_i,
    input wire logic [23:0]                  reg_rdata_o,
    input wire sdm_cfg_pkg::sdm_mod_ctrl_type mod_ctrl_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    function automatic logic [23:0] seed_of(input logic [1:0] c);
        return c[1] ? (c[0] ? 24'h50F1CD : 24'hB29D08) : {23'h000000, c[0]};
    endfunction : seed_of
    ////////////////////////////////////////
    write_store_a: assert property (reg_req_i.wr && reg_req_i.addr == 5'h06 |=>
        reg_rdata_o == {1'b0, $past(reg_req_i.wdata[22:0])}) else $error("write not stored");
    seed_fire_a: assert property (frac_write_i && reg_rdata_o[8] |=> mod_ctrl_o.seed_load &&
        mod_ctrl_o.seed_value == seed_of($past(reg_rdata_o[1:0]))) else $error("seed load wrong");
    seed_hold_a: assert property (!(frac_write_i && reg_rdata_o[8]) |=>
        !mod_ctrl_o.seed_load && $stable(mod_ctrl_o.seed_value)) else $error("seed moved");
    order_decode_a: assert property (mod_ctrl_o.mode_a == (reg_rdata_o[3:2] == 2'h3) &&
        mod_ctrl_o.order_reserved == !reg_rdata_o[3]) else $error("order decode");
    gate_decode_a: assert property (mod_ctrl_o.use_modulator == !reg_rdata_o[7] &&
        mod_ctrl_o.core_enable == reg_rdata_o[11]) else $error("bypass or enable");
    clk_route_a: assert property (mod_ctrl_o.clk_src == (reg_rdata_o[10] ? 2'h1 :
        reg_rdata_o[21] ? 2'h0 : reg_rdata_o[9] ? 2'h2 : 2'h3)) else $error("clock route");
    rate_trim_a: assert property (mod_ctrl_o.rate_trim ==
        (reg_rdata_o[3:2] == 2'h3 ? reg_rdata_o[17:16] : 2'h0)) else $error("rate trim");
    test_start_a: assert property (reg_rdata_o[18] && !mod_ctrl_o.test_busy && !mod_ctrl_o.test_done
        |=> mod_ctrl_o.test_busy) else $error("self test start");
    test_stop_a: assert property (!reg_rdata_o[18] |=>
        !mod_ctrl_o.test_busy && !mod_ctrl_o.test_done) else $error("self test stop");
    cover property (mod_ctrl_o.seed_load);
    cover property (mod_ctrl_o.test_done);
    cover property (mod_ctrl_o.mode_a);
endmodule : sdm_cfg_regs_properties
bind sdm_cfg_regs sdm_cfg_regs_properties u_sdm_cfg_regs_properties (.ref_clk_i, .nrst_i,
    .reg_req_i, .frac_write_i, .refdiv_tick_i, .reg_rdata_o, .mod_ctrl_o);

// File: testbench/tb_sdm_cfg_regs.sv
// Testbench for the modulator configuration register
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end
module tb_sdm_cfg_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          ref_clk_i = 1'b0;
    logic                          nrst_i = 1'b0;
    logic                          frac_write_i = 1'b0;
    logic                          refdiv_tick_i = 1'b0;
    sdm_cfg_pkg::sdm_reg_req_type  req = '0;
    logic [23:0]                   rdata;
    sdm_cfg_pkg::sdm_mod_ctrl_type ctl;
    int                            num_errors = 0;
    int                            checked = 0;
    // Write data above, expected {clk_src, mode_a, reserved, use, core, rate_trim} below
    logic [31:0] rows [5] = '{32'h800B7A8C, 32'h03040758, 32'h23008C23, 32'h000F4A4C, 32'h000008C8};
    logic [23:0] seeds [4] = '{24'h000000, 24'h000001, 24'hB29D08, 24'h50F1CD};
    always #5 ref_clk_i = ~ref_clk_i;
    sdm_cfg_regs u_sdm_cfg_regs (.ref_clk_i, .nrst_i, .reg_req_i(req), .frac_write_i,
        .refdiv_tick_i, .reg_rdata_o(rdata), .mod_ctrl_o(ctl));
    ////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge ref_clk_i);
        req <= {1'b1, a, d};
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic fire();
        @(posedge ref_clk_i);
        frac_write_i <= 1'b1;
        @(posedge ref_clk_i);
        frac_write_i <= 1'b0;
        #1;
    endtask : fire
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            refdiv_tick_i <= 1'b1;
            @(posedge ref_clk_i);
            refdiv_tick_i <= 1'b0;
        end
        #1;
    endtask : tick
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // All four self-test lengths together need about 20600 cycles
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1;
        `CHK({rdata, ctl.seed_value}, {24'h000B7A, 24'hB29D08})
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(5'h06, rows[i][31:8]);
            `CHK(rdata, {1'b0, rows[i][30:8]})
            `CHK({ctl.clk_src, ctl.mode_a, ctl.order_reserved, ctl.use_modulator, ctl.core_enable, ctl.rate_trim}, rows[i][7:0])
        end
        // Other addresses must leave the register alone
        wr(5'h05, 24'h000000);
        `CHK(rdata, 24'h000008)
        for (int i = 0; i < 4; i++) begin
            wr(5'h06, 24'h000100 | 24'(i));
            fire();
            `CHK({ctl.seed_load, ctl.seed_value}, {1'b1, seeds[i]})
        end
        wr(5'h06, 24'h000002);
        fire();
        `CHK({ctl.seed_load, ctl.seed_value}, {1'b0, seeds[3]})
        for (int k = 0; k < 4; k++) begin
            wr(5'h06, 24'h040000 | 24'(k << 19));
            @(posedge ref_clk_i);
            #1;
            `CHK({ctl.test_busy, ctl.test_done}, 2'b10)
            tick(1022 + 1024 * k);
            `CHK({ctl.test_busy, ctl.test_done}, 2'b10)
            tick(1);
            `CHK({ctl.test_busy, ctl.test_done}, 2'b01)
            tick(1);
            `CHK({ctl.test_busy, ctl.test_done}, 2'b01)
            wr(5'h06, 24'h000000);
        end
        // Dropping the enable mid-run abandons the count
        wr(5'h06, 24'h040000);
        tick(3);
        wr(5'h06, 24'h000000);
        @(posedge ref_clk_i);
        #1;
        `CHK({ctl.test_busy, ctl.test_done}, 2'b00)
        // Reset after a seed load must bring back the reset word and seed
        wr(5'h06, 24'h000101);
        fire();
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK({rdata, ctl.seed_load, ctl.seed_value}, {24'h000B7A, 1'b0, 24'hB29D08})
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        wr(5'h06, 24'h000B7B);
        `CHK(rdata, 24'h000B7B)
        give_verdict();
    end
endmodule : tb_sdm_cfg_regs
